// File: pkg/srm_pkg.sv
// Shared constants, types and symbol decoders for the rate-match FIFO
package srm_pkg;
	localparam int         SYM_W     = 10;       // Aligned symbol width
	localparam int         RM_AW     = 4;        // Log2 of rate-match depth
	localparam int         BUF_DEPTH = 4;        // Output buffer words
	localparam int         PPM_TOTAL = 200;      // Offset absorbed, both sides
	// Symbols as {abcdei, fghj}, bit a in the MSB
	localparam logic [9:0] CTRL_POS  = 10'h305;  // K28.5, positive disparity
	localparam logic [9:0] SKIP_POS  = 10'h117;  // K29.7, positive disparity
	localparam logic [9:0] CTRL_NEG  = 10'h0fa;  // K28.5, negative disparity
	localparam logic [9:0] SKIP_NEG  = 10'h2e8;  // K29.7, negative disparity
	// Fill thresholds for a 16-deep FIFO
	localparam logic [4:0] FILL_HI   = 5'h0a;    // Delete at or above
	localparam logic [4:0] FILL_LO   = 5'h06;    // Insert at or below
	localparam logic [4:0] FILL_MAX  = 5'h0e;    // Extra deletions allowed
	localparam logic [4:0] FILL_MIN  = 5'h02;    // Extra insertions allowed
	localparam logic [1:0] RST_SYNC  = 2'h3;     // Link reset shifter at reset

	// Read-side sequencer states
	typedef enum logic {ST_PASS, ST_REPEAT} srm_rd_state_t;

	// Control symbol directly followed by its own skip symbol
	function automatic logic is_pair(input logic [9:0] prev, input logic [9:0] cur);
		is_pair = (prev == CTRL_POS && cur == SKIP_POS) ||
			(prev == CTRL_NEG && cur == SKIP_NEG);
	endfunction : is_pair

	// Symbol belongs to a control/skip cluster
	function automatic logic is_clus(input logic [9:0] s);
		is_clus = (s == CTRL_POS) || (s == SKIP_POS) ||
			(s == CTRL_NEG) || (s == SKIP_NEG);
	endfunction : is_clus
endpackage : srm_pkg

// File: pkg/srm_stream_if.sv
// Valid/ready symbol stream between the rate-match modules
`timescale 1ns/100ps
interface srm_stream_if #(
	parameter int W = 10  // Data width
);
	logic [W-1:0] data;   // Symbol
	logic         valid;  // Source offers data
	logic         ready;  // Sink accepts data

	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : srm_stream_if

// File: core/srm_buf_fifo.sv
// Single-clock output buffer with valid/ready on both sides
`timescale 1ns/100ps
module srm_buf_fifo #(
	parameter int W     = 10,  // Word width
	parameter int DEPTH = 4    // Words held
) (
	input  wire logic     clk,
	input  wire logic     rst,
	srm_stream_if.snk     in_s,
	srm_stream_if.src     out_s
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem [DEPTH];  // Storage, no reset needed
	logic [AW-1:0] wp;          // Write pointer
	logic [AW-1:0] rp;          // Read pointer
	logic [AW:0]   cnt;         // Words held

	wire push = in_s.valid && in_s.ready;
	wire pop  = out_s.valid && out_s.ready;
	wire [AW-1:0] next_wp = (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
	wire [AW-1:0] next_rp = (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;

	// Honest full and empty; full stalls the read sequencer upstream
	assign in_s.ready  = (cnt != (AW + 1)'(DEPTH));
	assign out_s.valid = (cnt != '0);
	assign out_s.data  = mem[rp];

	// Storage write
	always_ff @(posedge clk) begin
		if (push) mem[wp] <= in_s.data;
	end

	// Pointers and count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			if (push) wp <= next_wp;
			if (pop) rp <= next_rp;
			cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule : srm_buf_fifo

// File: core/srm_cdc_fifo.sv
// Dual-clock FIFO with gray-coded pointers and fill levels on both sides
`timescale 1ns/100ps
module srm_cdc_fifo #(
	parameter int W  = 10,  // Word width
	parameter int AW = 4    // Log2 of depth
) (
	input  wire logic        wr_clk,
	input  wire logic        wr_rst,
	input  wire logic        rd_clk,
	input  wire logic        rd_rst,
	srm_stream_if.snk        wr,
	srm_stream_if.src        rd,
	output logic [AW:0]      wr_fill,
	output logic [AW:0]      rd_fill
);
	logic [W-1:0] mem [2**AW];  // Storage, written on the link side
	logic [AW:0] wbin;           // Write pointer, binary
	logic [AW:0] wgray;          // Write pointer, gray
	logic [AW:0] rbin;           // Read pointer, binary
	logic [AW:0] rgray;          // Read pointer, gray
	logic [AW:0] rg_s1;          // Read pointer into write side, stage 1
	logic [AW:0] rg_s2;          // Stage 2
	logic [AW:0] wg_s1;          // Write pointer into read side, stage 1
	logic [AW:0] wg_s2;          // Stage 2

	// Gray to binary, used on both sides
	function automatic logic [AW:0] g2b(input logic [AW:0] g);
		logic [AW:0] b;
		b[AW] = g[AW];
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction : g2b

	wire push = wr.valid && wr.ready;
	wire pop  = rd.valid && rd.ready;
	wire [AW:0] next_wbin = wbin + (AW + 1)'(push);
	wire [AW:0] next_rbin = rbin + (AW + 1)'(pop);

	// Fill seen from each side lags the far pointer by the synchroniser
	assign wr_fill  = wbin - g2b(rg_s2);
	assign rd_fill  = g2b(wg_s2) - rbin;
	assign wr.ready = (wr_fill != (AW + 1)'(2**AW));
	assign rd.valid = (rd_fill != '0);
	assign rd.data  = mem[rbin[AW-1:0]];

	// Storage write
	always_ff @(posedge wr_clk) begin
		if (push) mem[wbin[AW-1:0]] <= wr.data;
	end

	// Write pointer and read pointer synchroniser
	always_ff @(posedge wr_clk or posedge wr_rst) begin
		if (wr_rst) begin
			wbin  <= '0;
			wgray <= '0;
			rg_s1 <= '0;
			rg_s2 <= '0;
		end else begin
			wbin  <= next_wbin;
			wgray <= next_wbin ^ (next_wbin >> 1);
			rg_s1 <= rgray;
			rg_s2 <= rg_s1;
		end
	end

	// Read pointer and write pointer synchroniser
	always_ff @(posedge rd_clk or posedge rd_rst) begin
		if (rd_rst) begin
			rbin  <= '0;
			rgray <= '0;
			wg_s1 <= '0;
			wg_s2 <= '0;
		end else begin
			rbin  <= next_rbin;
			rgray <= next_rbin ^ (next_rbin >> 1);
			wg_s1 <= wgray;
			wg_s2 <= wg_s1;
		end
	end
endmodule : srm_cdc_fifo

// File: core/srm_rate_match.sv
// Rate-match FIFO: link-side skip deletion, reference-side skip insertion
// How it works
// - Compensation is optional; off means plain pass-through
// - No insert or delete before link sync
// - Absorbs 200 ppm total clock offset
// - Control+skip pair lets a skip be inserted/deleted
// - One insert or delete per cluster normally
// - Pair one: K28.5 then K29.7, positive
// - Pair two: K28.5 then K29.7, negative
// - Beyond range, extra skips may be touched
`timescale 1ns/100ps
module srm_rate_match #(
	parameter int RM_AW  = srm_pkg::RM_AW,     // Log2 of rate-match depth
	parameter int BUF_DP = srm_pkg::BUF_DEPTH  // Output buffer words
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	input  wire logic                     link_clk,
	input  wire logic [srm_pkg::SYM_W-1:0] rx_symbol,
	input  wire logic                     rx_sync,
	input  wire logic                     rm_enable,
	output logic [srm_pkg::SYM_W-1:0]     out_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic                          sync_status,
	output logic                          rm_inserted,
	output logic                          rm_deleted
);
	localparam int FW = RM_AW + 1;  // Fill width

	// Thresholds sized to the fill; margins cover 200 ppm drift
	localparam logic [FW-1:0] TH_HI  = FW'(srm_pkg::FILL_HI);
	localparam logic [FW-1:0] TH_LO  = FW'(srm_pkg::FILL_LO);
	localparam logic [FW-1:0] TH_MAX = FW'(srm_pkg::FILL_MAX);
	localparam logic [FW-1:0] TH_MIN = FW'(srm_pkg::FILL_MIN);

	// Streams between the modules
	srm_stream_if #(.W(srm_pkg::SYM_W)) wq ();  // Link side into FIFO
	srm_stream_if #(.W(srm_pkg::SYM_W)) rq ();  // FIFO to sequencer
	srm_stream_if #(.W(srm_pkg::SYM_W)) bo ();  // Sequencer to buffer
	srm_stream_if #(.W(srm_pkg::SYM_W)) bq ();  // Buffer to user

	// Link-domain state
	logic [1:0]               lrst_sh;  // Link reset release shifter
	logic                     en_s1;    // Enable synchroniser, stage 1
	logic                     en_l;     // Enable in link domain
	logic [srm_pkg::SYM_W-1:0] sym_q;   // Current symbol
	logic [srm_pkg::SYM_W-1:0] prev_q;  // Symbol before it
	logic                     sync_q;   // Aligner sync, registered
	logic                     del_done; // Deletion made in this cluster
	logic                     del_tgl;  // Toggles once per deletion
	logic [FW-1:0]            wr_fill;  // Fill seen by the link side

	// Reference-domain state
	logic                     sy_s1;    // Sync synchroniser, stage 1
	logic                     sync_r;   // Sync in reference domain
	logic                     dt_s1;    // Deletion toggle, stage 1
	logic                     dt_s2;    // Stage 2
	logic                     dt_s3;    // Edge detect delay
	srm_pkg::srm_rd_state_t   state;    // Read sequencer state
	srm_pkg::srm_rd_state_t   next_state;
	logic [srm_pkg::SYM_W-1:0] prev_out; // Last symbol taken from FIFO
	logic [srm_pkg::SYM_W-1:0] rep_sym;  // Skip to be repeated
	logic                     ins_done; // Insertion made in this cluster
	logic [FW-1:0]            rd_fill;  // Fill seen by the read side

	wire link_rst = lrst_sh[1];

	// Link reset: asserted at once, released on link clock edges
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) lrst_sh <= srm_pkg::RST_SYNC;
		else lrst_sh <= {lrst_sh[0], 1'b0};
	end

	// Link-side decode
	wire comp_l   = en_l && sync_q;
	wire pair_hit = srm_pkg::is_pair(prev_q, sym_q);
	wire allow_dl = !del_done || (wr_fill >= TH_MAX);
	wire do_del   = comp_l && pair_hit && (wr_fill >= TH_HI) && allow_dl;

	// A deleted skip is simply not written; full drops a symbol
	assign wq.valid = !do_del;
	assign wq.data  = sym_q;

	// Symbol pipeline; symbols arrive on every recovered clock edge
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			sym_q  <= '0;
			prev_q <= '0;
			sync_q <= 1'b0;
		end else begin
			sym_q  <= rx_symbol;
			prev_q <= sym_q;
			sync_q <= rx_sync;
		end
	end

	// Enable is a quasi-static level; two flops bring it over
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			en_s1 <= 1'b0;
			en_l  <= 1'b0;
		end else begin
			en_s1 <= rm_enable;
			en_l  <= en_s1;
		end
	end

	// Cluster tracking for deletions; any data symbol ends the cluster
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			del_done <= 1'b0;
			del_tgl  <= 1'b0;
		end else begin
			if (do_del) del_done <= 1'b1;
			else if (!srm_pkg::is_clus(sym_q)) del_done <= 1'b0;
			if (do_del) del_tgl <= !del_tgl;
		end
	end

	// Rate-match FIFO between the two clocks
	srm_cdc_fifo #(
		.W  (srm_pkg::SYM_W),
		.AW (RM_AW)
	) u_cdc (
		.wr_clk  (link_clk),
		.wr_rst  (link_rst),
		.rd_clk  (ref_clk),
		.rd_rst  (rst),
		.wr      (wq.snk),
		.rd      (rq.src),
		.wr_fill (wr_fill),
		.rd_fill (rd_fill)
	);

	// Sync level and deletion toggle into the reference domain
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sy_s1  <= 1'b0;
			sync_r <= 1'b0;
			dt_s1  <= 1'b0;
			dt_s2  <= 1'b0;
			dt_s3  <= 1'b0;
		end else begin
			sy_s1  <= sync_q;
			sync_r <= sy_s1;
			dt_s1  <= del_tgl;
			dt_s2  <= dt_s1;
			dt_s3  <= dt_s2;
		end
	end

	// Read-side decode
	wire comp_r   = rm_enable && sync_r;
	wire ins_pair = srm_pkg::is_pair(prev_out, rq.data);
	wire allow_in = !ins_done || (rd_fill <= TH_MIN);
	wire take     = rq.valid && rq.ready;
	wire do_ins   = take && comp_r && ins_pair && (rd_fill <= TH_LO) && allow_in;

	// Repeating a skip holds the FIFO, so no symbol is lost
	assign bo.valid = (state == srm_pkg::ST_REPEAT) || rq.valid;
	assign bo.data  = (state == srm_pkg::ST_REPEAT) ? rep_sym : rq.data;
	assign rq.ready = (state == srm_pkg::ST_PASS) && bo.ready;

	// Sequencer next state
	always_comb begin
		next_state = state;
		unique case (state)
			srm_pkg::ST_PASS: begin
				if (do_ins) next_state = srm_pkg::ST_REPEAT;
			end
			srm_pkg::ST_REPEAT: begin
				if (bo.ready) next_state = srm_pkg::ST_PASS;
			end
		endcase
	end

	// Sequencer registers and cluster tracking for insertions
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state       <= srm_pkg::ST_PASS;
			prev_out    <= '0;
			rep_sym     <= '0;
			ins_done    <= 1'b0;
			rm_inserted <= 1'b0;
			rm_deleted  <= 1'b0;
		end else begin
			state       <= next_state;
			rm_inserted <= do_ins;
			rm_deleted  <= dt_s2 ^ dt_s3;
			if (take) prev_out <= rq.data;
			if (do_ins) rep_sym <= rq.data;
			if (do_ins) ins_done <= 1'b1;
			else if (take && !srm_pkg::is_clus(rq.data)) ins_done <= 1'b0;
		end
	end

	// Output buffer; a stalled user fills it and then stalls the FIFO
	srm_buf_fifo #(
		.W     (srm_pkg::SYM_W),
		.DEPTH (BUF_DP)
	) u_buf (
		.clk   (ref_clk),
		.rst   (rst),
		.in_s  (bo.snk),
		.out_s (bq.src)
	);

	assign out_data    = bq.data;
	assign out_valid   = bq.valid;
	assign bq.ready    = out_ready;
	assign sync_status = sync_r;

	// Disabled: every received symbol is offered to the FIFO unchanged; the first
	// edge after link reset is skipped, the pipeline still holds its reset value
	a_bypass_all: assert property (
		@(posedge link_clk) disable iff (link_rst)
		!en_l && !$past(link_rst) |-> wq.valid && wq.data == $past(rx_symbol))
		else $error("symbol dropped while compensation is off");

	// Unsynchronised: the sequencer never starts a repeat
	a_hold_unsynced: assert property (
		@(posedge ref_clk) disable iff (rst)
		(!sync_r && state == srm_pkg::ST_PASS) |=> state == srm_pkg::ST_PASS)
		else $error("insertion before link sync");

	// A write that is not offered is always a justified deletion
	a_del_cause: assert property (
		@(posedge link_clk) disable iff (link_rst)
		!wq.valid |-> comp_l && pair_hit && wr_fill >= TH_HI)
		else $error("deletion without pair or high fill");

	// Positive pair is recognised
	a_pair_pos: assert property (
		@(posedge link_clk) disable iff (link_rst)
		(prev_q == srm_pkg::CTRL_POS && sym_q == srm_pkg::SKIP_POS) |-> pair_hit)
		else $error("positive pair missed");

	// Negative pair is recognised
	a_pair_neg: assert property (
		@(posedge link_clk) disable iff (link_rst)
		(prev_q == srm_pkg::CTRL_NEG && sym_q == srm_pkg::SKIP_NEG) |-> pair_hit)
		else $error("negative pair missed");

	// Normal fill: one deletion per cluster
	a_one_del: assert property (
		@(posedge link_clk) disable iff (link_rst)
		do_del && wr_fill < TH_MAX |-> !del_done)
		else $error("second deletion in a cluster");

	// Normal fill: one insertion per cluster
	a_one_ins: assert property (
		@(posedge ref_clk) disable iff (rst)
		do_ins && rd_fill > TH_MIN |-> !ins_done)
		else $error("second insertion in a cluster");

	// Extra deletions only near overflow
	a_extra_del: assert property (
		@(posedge link_clk) disable iff (link_rst)
		do_del && del_done |-> wr_fill >= TH_MAX)
		else $error("extra deletion without overflow risk");

	// A repeat re-sends the skip and holds the FIFO until taken
	a_repeat_hold: assert property (
		@(posedge ref_clk) disable iff (rst)
		do_ins |=> (state == srm_pkg::ST_REPEAT && !rq.ready &&
			bo.data == $past(rq.data)) [*1] ##0 (bo.valid))
		else $error("repeat did not hold the FIFO");

	// Every insertion shows as one pulse on the next edge
	a_ins_pulse: assert property (
		@(posedge ref_clk) disable iff (rst)
		do_ins |=> rm_inserted)
		else $error("insertion without a pulse");

	// Extra insertions only near underflow
	a_extra_ins: assert property (
		@(posedge ref_clk) disable iff (rst)
		do_ins && ins_done |-> rd_fill <= TH_MIN)
		else $error("extra insertion without underflow risk");

	// Each deletion flips the toggle that crosses to the reference side
	a_del_toggle: assert property (
		@(posedge link_clk) disable iff (link_rst)
		do_del |=> del_tgl != $past(del_tgl))
		else $error("deletion not signalled across");

	// Any data symbol ends the cluster, so a later pair may lose a skip again
	a_clus_end: assert property (
		@(posedge link_clk) disable iff (link_rst)
		!srm_pkg::is_clus(sym_q) && !do_del |=> !del_done)
		else $error("cluster flag survived a data symbol");

	// A repeat lasts one accepted word, so only one copy is added
	a_repeat_once: assert property (
		@(posedge ref_clk) disable iff (rst)
		state == srm_pkg::ST_REPEAT && bo.ready |=> state == srm_pkg::ST_PASS)
		else $error("repeat sent more than one extra skip");

	// A stalled output stands with its word unchanged
	a_out_hold: assert property (
		@(posedge ref_clk) disable iff (rst)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("output word changed while stalled");
endmodule : srm_rate_match

// File: verif/srm_link_tx.sv
// Upstream transmitter model: one aligned symbol on every link clock edge
`timescale 1ns/100ps
module srm_link_tx (
	input  wire logic       link_clk,
	input  wire logic       sync_req,
	output logic [9:0]      rx_symbol,
	output logic            rx_sync
);
	localparam logic [9:0] FILL_SYM = 10'h2aa;  // Idle data code, never a cluster code
	logic [9:0]            txq[$];              // Symbols queued by the bench

	initial begin
		rx_symbol = FILL_SYM;
		rx_sync   = 1'b0;
	end

	// Queued symbols go out back to back; the idle code fills every gap,
	// since a recovered link never pauses. Exactly one symbol per edge.
	always @(posedge link_clk) begin
		#1;
		rx_sync = sync_req;
		if (txq.size() != 0) begin
			rx_symbol = txq.pop_front();
		end else begin
			rx_symbol = FILL_SYM;
		end
	end

	// Queue one symbol for the link
	task automatic send(input logic [9:0] s);
		txq.push_back(s);
	endtask : send

	// Symbols still waiting to go out
	function automatic int pending();
		return txq.size();
	endfunction : pending
endmodule : srm_link_tx

// File: verif/tb_srm_rate_match.sv
// Self-checking bench for the rate-match FIFO behind an upstream transmitter
`timescale 1ns/100ps
module tb_srm_rate_match;
	localparam logic [9:0] FILL_SYM = 10'h2aa;  // Idle code from the model
	localparam logic [9:0] MARK_SYM = 10'h0a5;  // Data code that closes a cluster
	logic       ref_clk;      // 100 MHz reference
	logic       link_clk;     // 15 ns recovered clock
	logic       rst;          // Active-high reset
	logic       sync_req;     // Sync level handed to the model
	logic       rm_enable;    // Compensation on
	logic       out_ready;    // Consumer ready
	logic [9:0] rx_symbol;    // From the model
	logic       rx_sync;      // From the model
	logic [9:0] out_data;     // Output symbol
	logic       out_valid;    // Output valid
	logic       sync_status;  // Crossed sync
	logic       rm_inserted;  // Insert pulse
	logic       rm_deleted;   // Delete pulse
	int         mismatches;   // Failed comparisons
	int         n_compared;   // All comparisons
	int         n_ins, n_del, n_skip, n_ctrl, n_mark;  // Per-case tallies
	logic [9:0] seen[$];      // Non-idle symbols taken

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;
	// Link clock free of the reference phase; steady offset, no drift
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	srm_rate_match srm_rate_match_i (
		.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .rx_symbol(rx_symbol),
		.rx_sync(rx_sync), .rm_enable(rm_enable), .out_data(out_data),
		.out_valid(out_valid), .out_ready(out_ready), .sync_status(sync_status),
		.rm_inserted(rm_inserted), .rm_deleted(rm_deleted));

	srm_link_tx srm_link_tx_i (
		.link_clk(link_clk), .sync_req(sync_req), .rx_symbol(rx_symbol), .rx_sync(rx_sync));

	// Tally what the consumer takes and every flag pulse
	always @(posedge ref_clk) begin
		if (rst === 1'b0) begin
			if (out_valid === 1'b1 && out_ready === 1'b1 && out_data !== FILL_SYM) begin
				seen.push_back(out_data);
				if (out_data === srm_pkg::SKIP_POS || out_data === srm_pkg::SKIP_NEG) n_skip++;
				if (out_data === srm_pkg::CTRL_POS || out_data === srm_pkg::CTRL_NEG) n_ctrl++;
				if (out_data === MARK_SYM) n_mark++;
			end
			if (rm_inserted === 1'b1) n_ins++;
			if (rm_deleted === 1'b1) n_del++;
		end
	end

	task automatic cmp_sym(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: symbol %h, expected %h", $time, got, exp);
		end
	endtask : cmp_sym

	task automatic cmp_cnt(input int got, input int exp);
		n_compared++;
		if (got != exp) begin
			mismatches++;
			$display("Error at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask : cmp_cnt

	task automatic cmp_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask : cmp_bit

	// Two pairs and a closing code; a stall of ten or eleven link edges lifts
	// the link-side fill to 10..13 at the pairs, in the single-deletion band
	// and short of full; the long lead lets an earlier backlog drain first
	task automatic run_case(input logic en, input logic sy, input logic [9:0] c,
			input logic [9:0] s, input int stall);
		int k;
		out_ready = 1'b1;
		repeat (40) @(posedge ref_clk);
		#1;
		rm_enable = en;
		sync_req  = sy;
		repeat (12) @(posedge ref_clk);
		#1;
		cmp_bit(sync_status, sy);
		{n_ins, n_del, n_skip, n_ctrl, n_mark} = '0;
		seen.delete();
		out_ready = (stall == 0);
		repeat (stall) @(posedge link_clk);
		srm_link_tx_i.send(c);
		srm_link_tx_i.send(s);
		srm_link_tx_i.send(c);
		srm_link_tx_i.send(s);
		srm_link_tx_i.send(MARK_SYM);
		k = 0;
		while (srm_link_tx_i.pending() != 0 && k < 100) begin
			@(posedge link_clk);
			k++;
		end
		@(posedge ref_clk);
		#1;
		out_ready = 1'b1;
		k = 0;
		while (n_mark == 0 && k < 300) begin
			@(posedge ref_clk);
			k++;
		end
		// Deletion pulses trail by a few edges
		repeat (8) @(posedge ref_clk);
		cmp_cnt(n_mark, 1);
		cmp_cnt(n_ctrl, 2);
	endtask : run_case

	// Stream must come out untouched, in order, with no flag pulse
	task automatic chk_exact(input logic [9:0] c, input logic [9:0] s);
		logic [9:0] exp[5];
		exp = '{c, s, c, s, MARK_SYM};
		cmp_cnt(seen.size(), 5);
		for (int i = 0; i < 5 && i < seen.size(); i++) cmp_sym(seen[i], exp[i]);
		cmp_cnt(n_ins + n_del, 0);
	endtask : chk_exact

	task automatic test_disabled;
		run_case(1'b0, 1'b1, srm_pkg::CTRL_POS, srm_pkg::SKIP_POS, 10);
		chk_exact(srm_pkg::CTRL_POS, srm_pkg::SKIP_POS);
		$display("test_disabled done");
	endtask : test_disabled

	task automatic test_unsynced;
		run_case(1'b1, 1'b0, srm_pkg::CTRL_NEG, srm_pkg::SKIP_NEG, 10);
		chk_exact(srm_pkg::CTRL_NEG, srm_pkg::SKIP_NEG);
		$display("test_unsynced done");
	endtask : test_unsynced

	// High fill: one skip dropped, any later insertion counted back in
	task automatic test_delete(input logic [9:0] c, input logic [9:0] s);
		run_case(1'b1, 1'b1, c, s, 11);
		cmp_cnt(n_del, 1);
		cmp_cnt(n_skip, 1 + n_ins);
		cmp_cnt(int'(n_ins <= 1), 1);
		$display("test_delete %h done", c);
	endtask : test_delete

	// Low fill: the reference side reads faster than the link writes, so the
	// fill sits at the underflow floor and both pairs get their skip repeated
	task automatic test_insert(input logic [9:0] c, input logic [9:0] s);
		run_case(1'b1, 1'b1, c, s, 0);
		cmp_cnt(n_ins, 2);
		cmp_cnt(n_del, 0);
		cmp_cnt(n_skip, 4);
		cmp_cnt(seen.size(), 7);
		cmp_sym((seen.size() > 2) ? seen[2] : 10'h000, s);
		cmp_sym((seen.size() > 5) ? seen[5] : 10'h000, s);
		$display("test_insert %h done", c);
	endtask : test_insert

	task automatic close_out;
		$display("Counts: %0d compared, %0d mismatches", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	// Six cases of about a microsecond each; ample margin
	initial begin
		#60000;
		mismatches++;
		$display("Error at %0t: watchdog expired", $time);
		close_out();
	end

	// Main sequence
	initial begin
		{n_ins, n_del, n_skip, n_ctrl, n_mark} = '0;
		mismatches = 0;
		n_compared = 0;
		rst        = 1'b1;
		sync_req   = 1'b0;
		rm_enable  = 1'b0;
		out_ready  = 1'b1;
		repeat (8) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		test_disabled();
		test_unsynced();
		test_delete(srm_pkg::CTRL_POS, srm_pkg::SKIP_POS);
		test_delete(srm_pkg::CTRL_NEG, srm_pkg::SKIP_NEG);
		test_insert(srm_pkg::CTRL_POS, srm_pkg::SKIP_POS);
		test_insert(srm_pkg::CTRL_NEG, srm_pkg::SKIP_NEG);
		close_out();
	end
endmodule : tb_srm_rate_match
